// File: pkg/scdma_defines.svh
// Purpose: Register indices, field positions and reset values of the DMA
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef SCDMA_DEFINES_SVH
`define SCDMA_DEFINES_SVH
`define SCDMA_IDX_CTRL0L   14'h3E00
`define SCDMA_IDX_CTRL0H   14'h3E01
`define SCDMA_IDX_CTRL1L   14'h3E02
`define SCDMA_IDX_CTRL1H   14'h3E03
`define SCDMA_IDX_SRCL     14'h3E04
`define SCDMA_IDX_SRCM     14'h3E05
`define SCDMA_IDX_SRCH     14'h3E06
`define SCDMA_IDX_DSTL     14'h3E08
`define SCDMA_IDX_DSTM     14'h3E09
`define SCDMA_IDX_DSTH     14'h3E0A
`define SCDMA_IDX_CNTL     14'h3E0C
`define SCDMA_IDX_CNTH     14'h3E0D
`define SCDMA_IDX_IRQST    14'h3E10
`define SCDMA_IDX_IRQMSK   14'h3E11
`define SCDMA_B_SRC_FIX    7
`define SCDMA_B_UNIT       5
`define SCDMA_B_SINGLE     3
`define SCDMA_B_DST_FIX    1
`define SCDMA_B_ENABLE     0
`define SCDMA_B_ERR        4
`define SCDMA_B_BUSY       0
`define SCDMA_TRIG_SW      5'h00
`define SCDMA_RESP_OKAY    2'h0
`define SCDMA_RESP_SLVERR  2'h2
`define SCDMA_RST_BYTE     8'h00
`endif

// File: pkg/scdma_pkg.sv
// Purpose: Types shared by the DMA controller
// Assumes: Constants live in scdma_defines.svh
// Notes:   Event bits: 0 done, 1 add request, 2 error
package scdma_pkg;
  typedef enum logic [1:0] {
    SCDMA_IDLE  = 2'b00,
    SCDMA_READ  = 2'b01,
    SCDMA_WRITE = 2'b10
  } scdma_state_t;

  typedef struct packed {
    logic       src_fixed;
    logic [4:0] trigger_select;
    logic       unit_size_sel;
    logic       single_mode_sel;
    logic       dest_addr_fixed;
  } scdma_cfg_t;

  typedef struct packed {
    logic error;
    logic add_req;
    logic done;
  } scdma_evt_t;
endpackage

// File: hdl/scdma_top.sv
// Purpose: Single-channel DMA with AXI4-Lite registers and bus arbiter
// Assumes: Trigger pins asynchronous; DMA holds MEM_REQ_O until ack
// Notes:   Byte registers sit in data bits 7:0 of each word
// Operation
// - Unit size bit selects 8-bit or 16-bit transfer units.
// - Ten-bit count allows up to 1023 units per job.
// - Jobs start from external, internal peripheral or software triggers.
// - Mode bit 0 selects burst, 1 selects single transfer.
// - Software may stop a running job early.
// - DMA wins the memory bus over the processor.
// - Processor uses the bus whenever the DMA does not.
// - Source address steps per unit unless the fixed bit is set.
// - Code 0 is software; codes 1 to 8 select external interrupts.
// - Codes 9 to 20 select timer interrupt or capture sources.
// - Codes 21 to 30 serial sources; code 31 A/D conversion.
// - Source, destination and count live at fixed byte registers.
// - Enable waits for trigger, clears after last unit, stop on clear.
// - Count decrements per unit; zero is prohibited.
// - Single moves one unit per trigger; burst moves all; done event.
// - Early trigger sets error; trigger after last read asks more.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "scdma_defines.svh"
module scdma_top #(
  parameter int ADDR_W = 16,
  parameter int CNT_W  = 10
) (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [15:0] S_AWADDR_I,
  input  wire logic        S_AWVALID_I,
  output logic             S_AWREADY_O,
  input  wire logic [31:0] S_WDATA_I,
  input  wire logic [3:0]  S_WSTRB_I,
  input  wire logic        S_WVALID_I,
  output logic             S_WREADY_O,
  output logic [1:0]       S_BRESP_O,
  output logic             S_BVALID_O,
  input  wire logic        S_BREADY_I,
  input  wire logic [15:0] S_ARADDR_I,
  input  wire logic        S_ARVALID_I,
  output logic             S_ARREADY_O,
  output logic [31:0]      S_RDATA_O,
  output logic [1:0]       S_RRESP_O,
  output logic             S_RVALID_O,
  input  wire logic        S_RREADY_I,
  input  wire logic [31:1] TRIG_I,
  output logic             MEM_REQ_O,
  output logic             MEM_WE_O,
  output logic             MEM_WIDE_O,
  output logic [16:0]      MEM_ADDR_O,
  output logic [15:0]      MEM_WDATA_O,
  input  wire logic [15:0] MEM_RDATA_I,
  input  wire logic        MEM_ACK_I,
  input  wire logic        CPU_REQ_I,
  output logic             CPU_GNT_O,
  output logic             IRQ_O
);
  scdma_pkg::scdma_state_t st_q;
  scdma_pkg::scdma_cfg_t   cfg_q;
  scdma_pkg::scdma_evt_t   ist_q, imsk_q, evt;
  logic [16:0]      src_q, dst_q;
  logic [CNT_W-1:0] cnt_q;
  logic             en_q, err_q, busy_q, last_rd_q, sw_go_q;
  logic [31:1]      trig_s1_q, trig_s2_q, trig_s3_q;
  logic [15:0]      data_q;
  logic             awrdy_q, wrdy_q, aw_hold_q, w_hold_q, bvalid_q;
  logic [13:0]      aw_idx_q;
  logic [7:0]       wbyte_q;
  logic             wstb_q;
  logic [1:0]       bresp_q;
  logic             arrdy_q, rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;
  logic             irq_q, cpu_gnt_q;
  logic             wr_go, rd_go, trig, hw_edge, last_unit, mem_busy_d;
  logic [13:0]      ar_idx;

  function automatic logic idx_ok(input logic [13:0] i);
    case (i)
      `SCDMA_IDX_CTRL0L, `SCDMA_IDX_CTRL0H, `SCDMA_IDX_CTRL1L,
      `SCDMA_IDX_CTRL1H, `SCDMA_IDX_SRCL, `SCDMA_IDX_SRCM,
      `SCDMA_IDX_SRCH, `SCDMA_IDX_DSTL, `SCDMA_IDX_DSTM,
      `SCDMA_IDX_DSTH, `SCDMA_IDX_CNTL, `SCDMA_IDX_CNTH,
      `SCDMA_IDX_IRQST, `SCDMA_IDX_IRQMSK: idx_ok = 1'b1;
      default: idx_ok = 1'b0;
    endcase
  endfunction

  // Address after one unit: +1 byte or +2 bytes, or held
  function automatic logic [16:0] step(input logic [16:0] a,
                                       input logic fixed,
                                       input logic wide);
    if (fixed) begin
      step = a;
    end else begin
      step = a + (wide ? 17'h00002 : 17'h00001);
    end
  endfunction

  function automatic logic match(input logic go, input logic [13:0] i,
                                 input logic [13:0] r);
    match = go && (i == r);
  endfunction

  // Write performed when both halves are held, byte 0 strobe is set and no response pending
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q && wstb_q;
  assign ar_idx = S_ARADDR_I[15:2];
  assign rd_go  = S_ARVALID_I && arrdy_q;
  assign last_unit = (cnt_q == 10'h001);

  // Trigger pins: two-stage sync, third stage for edge detect
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      trig_s1_q <= '0;
      trig_s2_q <= '0;
      trig_s3_q <= '0;
    end else begin
      trig_s1_q <= TRIG_I;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // Selected source, rising edge only
  always_comb begin
    hw_edge = 1'b0;
    if (cfg_q.trigger_select != `SCDMA_TRIG_SW) begin
      hw_edge = trig_s2_q[cfg_q.trigger_select] &&
                !trig_s3_q[cfg_q.trigger_select];
    end
  end
  assign trig = (cfg_q.trigger_select == `SCDMA_TRIG_SW) ? sw_go_q
                                                         : hw_edge;

  // Event detection
  always_comb begin
    evt.done    = (st_q == scdma_pkg::SCDMA_WRITE) && MEM_ACK_I &&
                  last_unit;
    evt.add_req = trig && last_rd_q;
    evt.error   = trig && (st_q != scdma_pkg::SCDMA_IDLE) &&
                  ((st_q == scdma_pkg::SCDMA_READ) ||
                   (!cfg_q.single_mode_sel && !last_rd_q));
  end

  // AXI4-Lite write channels
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      awrdy_q   <= 1'b1;
      wrdy_q    <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SCDMA_RESP_OKAY;
      aw_idx_q  <= 14'h0000;
      wbyte_q   <= `SCDMA_RST_BYTE;
      wstb_q    <= 1'b0;
    end else begin
      if (S_AWVALID_I && awrdy_q) begin
        aw_hold_q <= 1'b1;
        awrdy_q   <= 1'b0;
        aw_idx_q  <= S_AWADDR_I[15:2];
      end
      if (S_WVALID_I && wrdy_q) begin
        w_hold_q <= 1'b1;
        wrdy_q   <= 1'b0;
        wbyte_q  <= S_WDATA_I[7:0];
        wstb_q   <= S_WSTRB_I[0];
      end
      if (aw_hold_q && w_hold_q && !bvalid_q) begin
        bvalid_q <= 1'b1;
        bresp_q  <= idx_ok(aw_idx_q) ? `SCDMA_RESP_OKAY
                                     : `SCDMA_RESP_SLVERR;
      end
      if (bvalid_q && S_BREADY_I) begin
        bvalid_q  <= 1'b0;
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        wstb_q    <= 1'b0;
        awrdy_q   <= 1'b1;
        wrdy_q    <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      arrdy_q  <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `SCDMA_RESP_OKAY;
    end else if (rd_go) begin
      arrdy_q  <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q  <= idx_ok(ar_idx) ? `SCDMA_RESP_OKAY : `SCDMA_RESP_SLVERR;
      case (ar_idx)
        `SCDMA_IDX_CTRL0L: rdata_q <= {24'h0, cfg_q.src_fixed, 2'b00,
                                       cfg_q.trigger_select};
        `SCDMA_IDX_CTRL0H: rdata_q <= {24'h0, 2'b00, cfg_q.unit_size_sel,
                                       1'b0, cfg_q.single_mode_sel, 1'b0,
                                       cfg_q.dest_addr_fixed, 1'b0};
        `SCDMA_IDX_CTRL1L: rdata_q <= {31'h0, en_q};
        `SCDMA_IDX_CTRL1H: rdata_q <= {24'h0, 3'b000, err_q, 3'b000,
                                       busy_q};
        `SCDMA_IDX_SRCL:   rdata_q <= {24'h0, src_q[7:0]};
        `SCDMA_IDX_SRCM:   rdata_q <= {24'h0, src_q[15:8]};
        `SCDMA_IDX_SRCH:   rdata_q <= {31'h0, src_q[16]};
        `SCDMA_IDX_DSTL:   rdata_q <= {24'h0, dst_q[7:0]};
        `SCDMA_IDX_DSTM:   rdata_q <= {24'h0, dst_q[15:8]};
        `SCDMA_IDX_DSTH:   rdata_q <= {31'h0, dst_q[16]};
        `SCDMA_IDX_CNTL:   rdata_q <= {24'h0, cnt_q[7:0]};
        `SCDMA_IDX_CNTH:   rdata_q <= {30'h0, cnt_q[9:8]};
        `SCDMA_IDX_IRQST:  rdata_q <= {29'h0, ist_q};
        `SCDMA_IDX_IRQMSK: rdata_q <= {29'h0, imsk_q};
        default:           rdata_q <= 32'h00000000;
      endcase
    end else if (rvalid_q && S_RREADY_I) begin
      rvalid_q <= 1'b0;
      arrdy_q  <= 1'b1;
    end
  end

  // Setup registers; changed by software writes only
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cfg_q <= '0;
    end else if (match(wr_go, aw_idx_q, `SCDMA_IDX_CTRL0L)) begin
      cfg_q.src_fixed      <= wbyte_q[`SCDMA_B_SRC_FIX];
      cfg_q.trigger_select <= wbyte_q[4:0];
    end else if (match(wr_go, aw_idx_q, `SCDMA_IDX_CTRL0H)) begin
      cfg_q.unit_size_sel   <= wbyte_q[`SCDMA_B_UNIT];
      cfg_q.single_mode_sel <= wbyte_q[`SCDMA_B_SINGLE];
      cfg_q.dest_addr_fixed <= wbyte_q[`SCDMA_B_DST_FIX];
    end
  end

  // Source and destination addresses step per unit
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      src_q <= 17'h00000;
      dst_q <= 17'h00000;
    end else begin
      if ((st_q == scdma_pkg::SCDMA_WRITE) && MEM_ACK_I) begin
        src_q <= step(src_q, cfg_q.src_fixed, cfg_q.unit_size_sel);
        dst_q <= step(dst_q, cfg_q.dest_addr_fixed, cfg_q.unit_size_sel);
      end
      if (match(wr_go, aw_idx_q, `SCDMA_IDX_SRCL)) src_q[7:0] <= wbyte_q;
      if (match(wr_go, aw_idx_q, `SCDMA_IDX_SRCM)) src_q[15:8] <= wbyte_q;
      if (match(wr_go, aw_idx_q, `SCDMA_IDX_SRCH)) src_q[16] <= wbyte_q[0];
      if (match(wr_go, aw_idx_q, `SCDMA_IDX_DSTL)) dst_q[7:0] <= wbyte_q;
      if (match(wr_go, aw_idx_q, `SCDMA_IDX_DSTM)) dst_q[15:8] <= wbyte_q;
      if (match(wr_go, aw_idx_q, `SCDMA_IDX_DSTH)) dst_q[16] <= wbyte_q[0];
    end
  end

  // Transfer count, one less per finished unit
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cnt_q <= '0;
    end else if (match(wr_go, aw_idx_q, `SCDMA_IDX_CNTL)) begin
      cnt_q[7:0] <= wbyte_q;
    end else if (match(wr_go, aw_idx_q, `SCDMA_IDX_CNTH)) begin
      cnt_q[9:8] <= wbyte_q[1:0];
    end else if ((st_q == scdma_pkg::SCDMA_WRITE) && MEM_ACK_I) begin
      cnt_q <= cnt_q - 10'h001;
    end
  end

  // Enable, error flag and software start pulse
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      en_q    <= 1'b0;
      err_q   <= 1'b0;
      sw_go_q <= 1'b0;
    end else begin
      sw_go_q <= match(wr_go, aw_idx_q, `SCDMA_IDX_CTRL1L) &&
                 wbyte_q[`SCDMA_B_ENABLE] &&
                 (cfg_q.trigger_select == `SCDMA_TRIG_SW);
      if (match(wr_go, aw_idx_q, `SCDMA_IDX_CTRL1L)) begin
        en_q <= wbyte_q[`SCDMA_B_ENABLE];
      end else if (evt.done) begin
        en_q <= 1'b0;
      end else if (en_q && (cnt_q == 10'h000) &&
                   (st_q == scdma_pkg::SCDMA_IDLE)) begin
        en_q <= 1'b0; // Zero count never starts
      end
      // Error set wins over the clear by enable write
      if (evt.error) begin
        err_q <= 1'b1;
      end else if (match(wr_go, aw_idx_q, `SCDMA_IDX_CTRL1L)) begin
        err_q <= 1'b0;
      end
    end
  end

  // Final read seen, until software writes the enable register again
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      last_rd_q <= 1'b0;
    end else if (match(wr_go, aw_idx_q, `SCDMA_IDX_CTRL1L)) begin
      last_rd_q <= 1'b0;
    end else if ((st_q == scdma_pkg::SCDMA_READ) && MEM_ACK_I &&
                 last_unit) begin
      last_rd_q <= 1'b1;
    end
  end

  // Transfer engine: read unit, then write it
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q        <= scdma_pkg::SCDMA_IDLE;
      busy_q      <= 1'b0;
      data_q      <= 16'h0000;
      MEM_REQ_O   <= 1'b0;
      MEM_WE_O    <= 1'b0;
      MEM_WIDE_O  <= 1'b0;
      MEM_ADDR_O  <= 17'h00000;
      MEM_WDATA_O <= 16'h0000;
    end else begin
      case (st_q)
        scdma_pkg::SCDMA_IDLE: begin
          if (trig && en_q && (cnt_q != 10'h000)) begin
            st_q       <= scdma_pkg::SCDMA_READ;
            busy_q     <= 1'b1;
            MEM_REQ_O  <= 1'b1;
            MEM_WE_O   <= 1'b0;
            MEM_WIDE_O <= cfg_q.unit_size_sel;
            MEM_ADDR_O <= src_q;
          end
        end
        scdma_pkg::SCDMA_READ: begin
          if (MEM_ACK_I) begin
            data_q <= MEM_RDATA_I;
            if (!en_q) begin
              // Stop once the bus access in flight is done
              st_q      <= scdma_pkg::SCDMA_IDLE;
              busy_q    <= 1'b0;
              MEM_REQ_O <= 1'b0;
            end else begin
              st_q        <= scdma_pkg::SCDMA_WRITE;
              MEM_WE_O    <= 1'b1;
              MEM_ADDR_O  <= dst_q;
              MEM_WDATA_O <= MEM_RDATA_I;
            end
          end
        end
        scdma_pkg::SCDMA_WRITE: begin
          if (MEM_ACK_I) begin
            MEM_WE_O <= 1'b0;
            if (last_unit || !en_q || cfg_q.single_mode_sel) begin
              st_q      <= scdma_pkg::SCDMA_IDLE;
              busy_q    <= 1'b0;
              MEM_REQ_O <= 1'b0;
            end else begin
              st_q       <= scdma_pkg::SCDMA_READ;
              MEM_ADDR_O <= step(src_q, cfg_q.src_fixed,
                                 cfg_q.unit_size_sel);
            end
          end
        end
        default: begin
          st_q      <= scdma_pkg::SCDMA_IDLE;
          busy_q    <= 1'b0;
          MEM_REQ_O <= 1'b0;
        end
      endcase
    end
  end

  // Bus wanted by the engine in the coming cycle
  always_comb begin
    mem_busy_d = MEM_REQ_O;
    if (MEM_ACK_I && (st_q == scdma_pkg::SCDMA_WRITE) &&
        (last_unit || !en_q || cfg_q.single_mode_sel)) begin
      mem_busy_d = 1'b0;
    end
    if (MEM_ACK_I && (st_q == scdma_pkg::SCDMA_READ) && !en_q) begin
      mem_busy_d = 1'b0;
    end
    if ((st_q == scdma_pkg::SCDMA_IDLE) && trig && en_q &&
        (cnt_q != 10'h000)) begin
      mem_busy_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cpu_gnt_q <= 1'b0;
    end else begin
      cpu_gnt_q <= CPU_REQ_I && !mem_busy_d;
    end
  end

  // Sticky events, cleared by status read; set wins
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ist_q  <= '0;
      imsk_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      if (match(rd_go, ar_idx, `SCDMA_IDX_IRQST)) begin
        ist_q <= evt;
      end else begin
        ist_q <= ist_q | evt;
      end
      if (match(wr_go, aw_idx_q, `SCDMA_IDX_IRQMSK)) begin
        imsk_q <= wbyte_q[2:0];
      end
      irq_q <= |(ist_q & imsk_q);
    end
  end

  assign S_AWREADY_O = awrdy_q;
  assign S_WREADY_O  = wrdy_q;
  assign S_BVALID_O  = bvalid_q;
  assign S_BRESP_O   = bresp_q;
  assign S_ARREADY_O = arrdy_q;
  assign S_RVALID_O  = rvalid_q;
  assign S_RDATA_O   = rdata_q;
  assign S_RRESP_O   = rresp_q;
  assign CPU_GNT_O   = cpu_gnt_q;
  assign IRQ_O       = irq_q;
endmodule

// File: sim/scdma_mem_model.sv
// Purpose: Memory bus partner that answers DMA read and write accesses
// Assumes: One-cycle ack; read data is a pattern of the address
// Notes:   wait_i sets the answer delay in cycles
`timescale 1ns/1ps
module scdma_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [3:0]  wait_i,
  output logic             ack_o,
  output logic [15:0]      rdata_o,
  output int               n_wr_o,
  output logic [16:0]      wr_addr_o,
  output logic [15:0]      wr_data_o
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt_q <= 4'h0;
      rdata_o <= 16'h0;
      n_wr_o <= 0;
      wr_addr_o <= 17'h0;
      wr_data_o <= 16'h0;
    end else if (req_i && !ack_o && cnt_q >= wait_i) begin
      ack_o <= 1'b1;
      cnt_q <= 4'h0;
      rdata_o <= {addr_i[7:0] ^ 8'h5A, addr_i[7:0]};
      if (we_i) begin
        n_wr_o <= n_wr_o + 1;
        wr_addr_o <= addr_i;
        wr_data_o <= wdata_i;
      end
    end else begin
      // Data is only valid with ack
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// File: sim/scdma_top_properties.sv
// Purpose: Port-level checks of the DMA controller
// Assumes: Single clock domain, active-low reset
// Notes:   Attached by bind
`timescale 1ns/1ps
module scdma_top_properties (
  input wire logic        CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        S_AWVALID_I,
  input wire logic        S_AWREADY_O,
  input wire logic        S_WVALID_I,
  input wire logic        S_WREADY_O,
  input wire logic        S_BVALID_O,
  input wire logic        S_BREADY_I,
  input wire logic        S_ARVALID_I,
  input wire logic        S_ARREADY_O,
  input wire logic        S_RVALID_O,
  input wire logic        S_RREADY_I,
  input wire logic [31:0] S_RDATA_O,
  input wire logic        MEM_REQ_O,
  input wire logic        MEM_WE_O,
  input wire logic [16:0] MEM_ADDR_O,
  input wire logic [15:0] MEM_WDATA_O,
  input wire logic [15:0] MEM_RDATA_I,
  input wire logic        MEM_ACK_I,
  input wire logic        CPU_REQ_I,
  input wire logic        CPU_GNT_O,
  input wire logic        IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  chk_gnt_excl: assert property (
    CPU_GNT_O |-> !MEM_REQ_O) else $error("grant during DMA access");
  chk_gnt_free: assert property (
    $past(RESET_N_I) |-> CPU_GNT_O == ($past(CPU_REQ_I) && !MEM_REQ_O))
    else $error("grant wrong while bus free");
  chk_mem_hold: assert property (
    MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O)
      && $stable(MEM_WE_O)) else $error("memory request not held");
  chk_wdata_copy: assert property (
    MEM_REQ_O && MEM_ACK_I && !MEM_WE_O ##1 MEM_REQ_O && MEM_WE_O
      |-> MEM_WDATA_O == $past(MEM_RDATA_I)) else $error("write data");
  chk_b_timing: assert property (
    S_AWVALID_I && S_AWREADY_O && S_WVALID_I && S_WREADY_O |=> ##1 S_BVALID_O)
    else $error("write response late");
  chk_b_done: assert property (
    S_BVALID_O && S_BREADY_I |=> !S_BVALID_O) else $error("bvalid stuck");
  chk_r_timing: assert property (
    S_ARVALID_I && S_ARREADY_O |=> S_RVALID_O && !S_ARREADY_O)
    else $error("read response late");
  chk_r_done: assert property (
    S_RVALID_O && S_RREADY_I |=> !S_RVALID_O && S_ARREADY_O)
    else $error("read channel not released");
  chk_rdata_byte: assert property (
    S_RVALID_O |-> S_RDATA_O[31:8] == 24'h0) else $error("upper data");
  cov_mem_write: cover property (MEM_REQ_O && MEM_WE_O && MEM_ACK_I);
  cov_cpu_gnt: cover property (CPU_GNT_O);
  cov_irq: cover property ($rose(IRQ_O));
endmodule
bind scdma_top scdma_top_properties scdma_top_properties_inst (.*);

// File: sim/testbench.sv
// Purpose: Self-checking bench of the DMA controller
// Assumes: Registers reached over AXI4-Lite, memory partner model
// Notes:   Scenarios run in sequence after reset
`timescale 1ns/1ps
`include "scdma_defines.svh"
module testbench;
  logic CLK_I, RESET_N_I, S_AWVALID_I, S_WVALID_I, S_BREADY_I;
  logic S_ARVALID_I, S_RREADY_I, CPU_REQ_I, MEM_ACK_I;
  logic S_AWREADY_O, S_WREADY_O, S_BVALID_O, S_ARREADY_O, S_RVALID_O;
  logic MEM_REQ_O, MEM_WE_O, MEM_WIDE_O, CPU_GNT_O, IRQ_O;
  logic [15:0] S_AWADDR_I, S_ARADDR_I, MEM_WDATA_O, MEM_RDATA_I;
  logic [31:0] S_WDATA_I, S_RDATA_O;
  logic [3:0] S_WSTRB_I, mem_wait;
  logic [1:0] S_BRESP_O, S_RRESP_O;
  logic [31:1] TRIG_I;
  logic [16:0] MEM_ADDR_O, wr_addr;
  logic [15:0] wr_data;
  int n_wr, failures, n_compared;
  scdma_top scdma_top_inst (.*);
  scdma_mem_model scdma_mem_model_inst (.clk_i(CLK_I), .rst_n_i(RESET_N_I),
    .req_i(MEM_REQ_O), .we_i(MEM_WE_O), .addr_i(MEM_ADDR_O),
    .wdata_i(MEM_WDATA_O), .wait_i(mem_wait), .ack_o(MEM_ACK_I),
    .rdata_o(MEM_RDATA_I), .n_wr_o(n_wr), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data));
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  function automatic logic [15:0] pat(input logic [16:0] a);
    return {a[7:0] ^ 8'h5A, a[7:0]};
  endfunction
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [13:0] ix, input logic [7:0] v,
                        output logic [1:0] r);
    int k;
    k = 0;
    @(posedge CLK_I);
    S_AWADDR_I <= {ix, 2'b00};
    S_WDATA_I <= {24'h0, v};
    S_AWVALID_I <= 1'b1;
    S_WVALID_I <= 1'b1;
    S_BREADY_I <= 1'b1;
    do begin
      @(posedge CLK_I);
      if (S_AWREADY_O) S_AWVALID_I <= 1'b0;
      if (S_WREADY_O) S_WVALID_I <= 1'b0;
    end while (S_BVALID_O !== 1'b1 && ++k < 100);
    S_BREADY_I <= 1'b0;
    r = S_BVALID_O === 1'b1 ? S_BRESP_O : 2'h3;
  endtask
  task automatic axi_rd(input logic [13:0] ix, output logic [31:0] d,
                        output logic [1:0] r);
    int k;
    k = 0;
    @(posedge CLK_I);
    S_ARADDR_I <= {ix, 2'b00};
    S_ARVALID_I <= 1'b1;
    S_RREADY_I <= 1'b1;
    do begin
      @(posedge CLK_I);
      if (S_ARREADY_O) S_ARVALID_I <= 1'b0;
    end while (S_RVALID_O !== 1'b1 && ++k < 100);
    S_RREADY_I <= 1'b0;
    d = S_RDATA_O;
    r = S_RVALID_O === 1'b1 ? S_RRESP_O : 2'h3;
  endtask
  task automatic wr(input logic [13:0] ix, input logic [7:0] v);
    logic [1:0] r;
    axi_wr(ix, v, r);
    check(r, `SCDMA_RESP_OKAY);
  endtask
  task automatic rdc(input logic [13:0] ix, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(ix, d, r);
    check({r, d}, {`SCDMA_RESP_OKAY, 24'h0, e});
  endtask
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    int k;
    k = 0;
    do begin
      axi_rd(`SCDMA_IDX_CTRL1L, d, r);
      k++;
    end while (d[0] !== 1'b0 && k < 3000);
  endtask
  task automatic wait_wr(input int n);
    int k;
    k = 0;
    while (n_wr != n && k < 5000) begin
      @(posedge CLK_I);
      k++;
    end
  endtask
  task automatic pulse(input int c, input int hi);
    @(posedge CLK_I);
    TRIG_I[c] <= 1'b1;
    repeat (hi) @(posedge CLK_I);
    TRIG_I[c] <= 1'b0;
    repeat (2) @(posedge CLK_I);
  endtask
  // Setup only while the engine is disabled
  task automatic setup(input logic [16:0] s, d, input logic [9:0] n,
                       input logic [7:0] c0l, c0h);
    wr(`SCDMA_IDX_SRCL, s[7:0]);
    wr(`SCDMA_IDX_SRCM, s[15:8]);
    wr(`SCDMA_IDX_SRCH, {7'h0, s[16]});
    wr(`SCDMA_IDX_DSTL, d[7:0]);
    wr(`SCDMA_IDX_DSTM, d[15:8]);
    wr(`SCDMA_IDX_DSTH, {7'h0, d[16]});
    wr(`SCDMA_IDX_CNTL, n[7:0]);
    wr(`SCDMA_IDX_CNTH, {6'h0, n[9:8]});
    wr(`SCDMA_IDX_CTRL0L, c0l);
    wr(`SCDMA_IDX_CTRL0H, c0h);
  endtask
  task automatic t_regs();
    logic [13:0] ix[7] = '{`SCDMA_IDX_CTRL0L, `SCDMA_IDX_CTRL0H,
      `SCDMA_IDX_CTRL1H, `SCDMA_IDX_SRCH, `SCDMA_IDX_DSTH,
      `SCDMA_IDX_CNTH, `SCDMA_IDX_SRCM};
    logic [7:0] ex[7] = '{8'h9F, 8'h2A, 8'h00, 8'h01, 8'h01, 8'h03, 8'hFF};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) rdc(ix[i], 8'h00);
    axi_rd(14'h3E07, d, r);
    check({r, d}, {`SCDMA_RESP_SLVERR, 32'h0});
    axi_wr(14'h3E0B, 8'hFF, r);
    check(r, `SCDMA_RESP_SLVERR);
    for (int i = 0; i < 7; i++) begin
      wr(ix[i], 8'hFF);
      rdc(ix[i], ex[i]);
    end
  endtask
  task automatic t_burst();
    int n0;
    n0 = n_wr;
    setup(17'h10, 17'h1FF00, 10'h3, 8'h00, 8'h00);
    wr(`SCDMA_IDX_CTRL1L, 8'h01);
    wait_idle();
    check(n_wr - n0, 3);
    check(MEM_WIDE_O, 1'b0);
    check({wr_addr, wr_data}, {17'h1FF02, pat(17'h12)});
    rdc(`SCDMA_IDX_CNTL, 8'h00);
    rdc(`SCDMA_IDX_SRCL, 8'h13);
    check(IRQ_O, 1'b0);
    wr(`SCDMA_IDX_IRQMSK, 8'h07);
    repeat (3) @(posedge CLK_I);
    check(IRQ_O, 1'b1);
    rdc(`SCDMA_IDX_IRQST, 8'h01);
    repeat (3) @(posedge CLK_I);
    check(IRQ_O, 1'b0);
  endtask
  task automatic t_single();
    int n0;
    n0 = n_wr;
    setup(17'h40, 17'h80, 10'h2, 8'h85, 8'h28);
    wr(`SCDMA_IDX_CTRL1L, 8'h01);
    pulse(5, 10);
    wait_wr(n0 + 1);
    repeat (10) @(posedge CLK_I);
    check(n_wr - n0, 1);
    rdc(`SCDMA_IDX_CNTL, 8'h01);
    rdc(`SCDMA_IDX_CTRL1L, 8'h01);
    pulse(5, 3);
    wait_idle();
    check({wr_addr, wr_data}, {17'h82, pat(17'h40)});
    check(MEM_WIDE_O, 1'b1);
    rdc(`SCDMA_IDX_SRCL, 8'h40);
  endtask
  task automatic t_codes();
    int n0;
    n0 = n_wr;
    setup(17'h500, 17'h600, 10'h1, 8'h01, 8'h08);
    for (int c = 1; c < 32; c++) begin
      wr(`SCDMA_IDX_CNTL, 8'h01);
      wr(`SCDMA_IDX_CTRL0L, 8'(c));
      wr(`SCDMA_IDX_CTRL1L, 8'h01);
      pulse(c, 3);
      wait_idle();
      check(n_wr - n0, c);
      check(wr_addr, 17'h5FF + 17'(c));
    end
    check(IRQ_O, 1'b1);
    pulse(31, 3);
    repeat (4) @(posedge CLK_I);
    rdc(`SCDMA_IDX_IRQST, 8'h03);
  endtask
  task automatic t_stop();
    logic [31:0] d;
    logic [1:0] r;
    logic [9:0] cnt;
    int n0;
    int n1;
    n0 = n_wr;
    mem_wait <= 4'h4;
    setup(17'h0, 17'h800, 10'h3FF, 8'h00, 8'h00);
    wr(`SCDMA_IDX_CTRL1L, 8'h01);
    repeat (60) @(posedge CLK_I);
    wr(`SCDMA_IDX_CTRL1L, 8'h00);
    repeat (20) @(posedge CLK_I);
    n1 = n_wr;
    repeat (40) @(posedge CLK_I);
    check(n_wr, n1);
    rdc(`SCDMA_IDX_CTRL1L, 8'h00);
    axi_rd(`SCDMA_IDX_CNTL, d, r);
    cnt[7:0] = d[7:0];
    axi_rd(`SCDMA_IDX_CNTH, d, r);
    cnt[9:8] = d[1:0];
    check(cnt, 10'h3FF - 10'(n1 - n0));
    axi_rd(`SCDMA_IDX_IRQST, d, r);
  endtask
  task automatic t_error();
    int n0;
    n0 = n_wr;
    mem_wait <= 4'h8;
    setup(17'h300, 17'h400, 10'h2, 8'h01, 8'h08);
    wr(`SCDMA_IDX_CTRL1L, 8'h01);
    pulse(1, 3);
    pulse(1, 3);
    wait_wr(n0 + 1);
    rdc(`SCDMA_IDX_CTRL1H, 8'h10);
    rdc(`SCDMA_IDX_IRQST, 8'h04);
    wr(`SCDMA_IDX_CTRL1L, 8'h00);
    rdc(`SCDMA_IDX_CTRL1H, 8'h00);
    mem_wait <= 4'h0;
  endtask
  task automatic test_done();
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge CLK_I);
    failures++;
    test_done();
  end
  initial begin
    {RESET_N_I, S_AWVALID_I, S_WVALID_I, S_BREADY_I} = 4'h0;
    {S_ARVALID_I, S_RREADY_I, CPU_REQ_I} = 3'h0;
    {S_AWADDR_I, S_ARADDR_I, S_WDATA_I} = 64'h0;
    S_WSTRB_I = 4'hF;
    TRIG_I = 31'h0;
    mem_wait = 4'h0;
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    CPU_REQ_I <= 1'b1;
    t_regs();
    t_burst();
    t_single();
    t_codes();
    t_stop();
    t_error();
    rdc(`SCDMA_IDX_CTRL1L, 8'h00);
    test_done();
  end
endmodule
